// [hw/otg_power_defines.svh]
// Offsets, field positions, reset values and timing counts for the bus power control block
`ifndef OTG_POWER_DEFINES_SVH
`define OTG_POWER_DEFINES_SVH

// ****************************************
// Transceiver register map
// ****************************************
`define OTG_ADDR_W          6
`define OTG_ADDR_WRITE      6'h0a
`define OTG_ADDR_SET        6'h0b
`define OTG_ADDR_CLEAR      6'h0c
`define OTG_RESET_VALUE     8'h06

// ****************************************
// Field positions of otg_power_control
// ****************************************
`define OTG_BIT_EXT_IND     7
`define OTG_BIT_EXT_SUPPLY  6
`define OTG_BIT_POWER_REQ   5
`define OTG_BIT_CHARGE      4
`define OTG_BIT_DISCHARGE   3
`define OTG_BIT_MINUS_PD    2
`define OTG_BIT_PLUS_PD     1
`define OTG_BIT_RESERVED    0

// ****************************************
// Report byte layout
// ****************************************
`define RPT_BIT_SESSION_END_FLAG    2
`define RPT_BIT_SESS_VALID  1
`define RPT_BIT_VBUS_VALID  0

// ****************************************
// Link controller APB map
// ****************************************
`define APB_OFF_COMMAND     12'h000
`define APB_OFF_STATUS      12'h004
`define CMD_ADDR_LSB        8
`define CMD_BIT_WRITE       16
`define ST_BIT_BUSY         0
`define ST_BIT_REFUSED      1
`define ST_BIT_DISCH_PEND   2
`define ST_BIT_SE0_OK       3
`define ST_BIT_SESSION_END_FLAG     4
`define ST_RDATA_LSB        8
`define ST_REPORT_LSB       16

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_MHZ        10
`define SE0_HOLD_US         2000
`define SE0_HOLD_CYCLES     (`SE0_HOLD_US * `CLK_FREQ_MHZ)

`endif

// [hw/otg_power_pkg.sv]
// Shared types of the bus power control block
package otg_power_pkg;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_WRITE,
    ACC_SET,
    ACC_CLEAR
  } access_e;

  typedef enum logic [0:0] {
    LINK_IDLE,
    LINK_WAIT
  } link_state_e;

endpackage : otg_power_pkg

// [hw/otg_power_if.sv]
// Register access and report channel between link controller and transceiver
`timescale 1ns/1ps

interface otg_power_if;
  logic       req_valid;
  logic       req_write;
  logic [5:0] req_addr;
  logic [7:0] req_wdata;
  logic       rsp_valid;
  logic [7:0] rsp_rdata;
  logic       rxcmd_valid;
  logic [7:0] rxcmd_data;

  modport device (
    input  req_valid,
    input  req_write,
    input  req_addr,
    input  req_wdata,
    output rsp_valid,
    output rsp_rdata,
    output rxcmd_valid,
    output rxcmd_data
  );

  modport link (
    output req_valid,
    output req_write,
    output req_addr,
    output req_wdata,
    input  rsp_valid,
    input  rsp_rdata,
    input  rxcmd_valid,
    input  rxcmd_data
  );
endinterface : otg_power_if

// [hw/otg_power_device.sv]
// Transceiver end: bus power control register, pin drive and comparator reports
`timescale 1ns/1ps
`include "otg_power_defines.svh"

module otg_power_device (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Link side
  otg_power_if.device     link,
  // Comparators and fault pin
  input  wire logic       session_end_flag,
  input  wire logic       session_valid_cmp,
  input  wire logic       vbus_valid_cmp,
  input  wire logic       fault_in,
  // Edge report enables, order {session end, session valid, vbus valid}
  input  wire logic [2:0] rise_report_en,
  input  wire logic [2:0] fall_report_en,
  // Power and resistor controls
  output logic            external_indicator_select,
  output logic            bus_power_request,
  output logic            bus_charge_enable,
  output logic            bus_discharge_enable,
  output logic            minus_line_pulldown_en,
  output logic            plus_line_pulldown_en,
  output logic            vbus_valid_indicator,
  // Open-drain external supply switch
  input  wire logic       power_switch_out_n_in,
  output logic            power_switch_out_n_out,
  output logic            power_switch_out_n_oe_n
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic otg_power_pkg::access_e decode_access(input logic [5:0] addr);
    otg_power_pkg::access_e kind;
    kind = otg_power_pkg::ACC_NONE;
    unique case (addr)
      `OTG_ADDR_WRITE: kind = otg_power_pkg::ACC_WRITE;
      `OTG_ADDR_SET:   kind = otg_power_pkg::ACC_SET;
      `OTG_ADDR_CLEAR: kind = otg_power_pkg::ACC_CLEAR;
      default:         kind = otg_power_pkg::ACC_NONE;
    endcase
    return kind;
  endfunction : decode_access

  logic [7:0]             otg_power_control_reg;
  logic [7:0]             otg_power_control_next;
  logic                   take;
  otg_power_pkg::access_e kind;
  logic                   rsp_valid_reg;
  logic [7:0]             rsp_rdata_reg;
  logic [2:0]             cmp_now;
  logic [2:0]             cmp_prev_reg;
  logic [2:0]             edge_hit;
  logic                   rxcmd_valid_reg;
  logic [7:0]             rxcmd_data_reg;
  logic                   vbus_ind;

  // A request is held until answered; skip the cycle of the answer so it is taken once
  assign take = link.req_valid && !rsp_valid_reg;
  assign kind = decode_access(link.req_addr);

  // ****************************************
  // Register update
  // ****************************************
  always_comb begin
    otg_power_control_next = otg_power_control_reg;
    if (take && link.req_write) begin
      unique case (kind)
        otg_power_pkg::ACC_WRITE: otg_power_control_next = link.req_wdata;
        otg_power_pkg::ACC_SET:   otg_power_control_next =
                                    otg_power_control_reg | link.req_wdata;
        otg_power_pkg::ACC_CLEAR: otg_power_control_next =
                                    otg_power_control_reg & ~link.req_wdata;
        otg_power_pkg::ACC_NONE:  otg_power_control_next = otg_power_control_reg;
      endcase
    end
  end

  // Bit 0 is stored as written; its effect is undefined, no output uses it and only register reads return it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otg_power_control_reg <= `OTG_RESET_VALUE;
    end else begin
      otg_power_control_reg <= otg_power_control_next;
    end
  end

  // ****************************************
  // Access answer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 8'h00;
    end else begin
      rsp_valid_reg <= take;
      if (take) begin
        // Any of the three addresses reads the register; others read zero
        if (kind != otg_power_pkg::ACC_NONE) begin
          rsp_rdata_reg <= otg_power_control_reg;
        end else begin
          rsp_rdata_reg <= 8'h00;
        end
      end
    end
  end

  assign link.rsp_valid = rsp_valid_reg;
  assign link.rsp_rdata = rsp_rdata_reg;

  // ****************************************
  // Power and resistor controls
  // ****************************************
  assign external_indicator_select = otg_power_control_reg[`OTG_BIT_EXT_IND];
  assign bus_power_request         = otg_power_control_reg[`OTG_BIT_POWER_REQ];
  assign bus_charge_enable         = otg_power_control_reg[`OTG_BIT_CHARGE];
  assign bus_discharge_enable      = otg_power_control_reg[`OTG_BIT_DISCHARGE];
  assign minus_line_pulldown_en    = otg_power_control_reg[`OTG_BIT_MINUS_PD];
  assign plus_line_pulldown_en     = otg_power_control_reg[`OTG_BIT_PLUS_PD];

  // Open drain: only ever drives low, never high
  assign power_switch_out_n_out  = 1'b0;
  assign power_switch_out_n_oe_n = ~otg_power_control_reg[`OTG_BIT_EXT_SUPPLY];

  // The external fault indicator replaces the internal comparator, not qualified by it
  assign vbus_ind = otg_power_control_reg[`OTG_BIT_EXT_IND] ? fault_in
                                                             : vbus_valid_cmp;
  assign vbus_valid_indicator = vbus_ind;

  // ****************************************
  // Comparator change reports
  // ****************************************
  always_comb begin
    cmp_now = 3'h0;
    cmp_now[`RPT_BIT_SESSION_END_FLAG]   = session_end_flag;
    cmp_now[`RPT_BIT_SESS_VALID] = session_valid_cmp;
    cmp_now[`RPT_BIT_VBUS_VALID] = vbus_ind;
  end

  assign edge_hit = (cmp_now & ~cmp_prev_reg & rise_report_en)
                  | (~cmp_now & cmp_prev_reg & fall_report_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_prev_reg <= 3'h0;
    end else begin
      cmp_prev_reg <= cmp_now;
    end
  end

  // One report per cycle carries the current session end and session valid levels and the selected VBUS indicator level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxcmd_valid_reg <= 1'b0;
      rxcmd_data_reg  <= 8'h00;
    end else begin
      rxcmd_valid_reg <= |edge_hit;
      if (|edge_hit) begin
        rxcmd_data_reg <= {5'h00, cmp_now};
      end
    end
  end

  assign link.rxcmd_valid = rxcmd_valid_reg;
  assign link.rxcmd_data  = rxcmd_data_reg;

  // The switch pin level is wired back for board checks only
  logic unused_switch_level;
  assign unused_switch_level = power_switch_out_n_in;

endmodule : otg_power_device

// [hw/otg_power_link.sv]
// Link controller end: APB command registers, guarded register access, discharge follow-up
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "otg_power_defines.svh"

module otg_power_link #(
  parameter int unsigned SE0_HOLD_CYCLES = `SE0_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Line state, high while both data lines sit at SE0
  input  wire logic        line_se0,
  // Transceiver side
  otg_power_if.link        phy
);

  logic                       apb_acc;
  logic                       cmd_hit;
  logic                       cmd_pending_reg;
  logic                       cmd_write_reg;
  logic [5:0]                 cmd_addr_reg;
  logic [7:0]                 cmd_data_reg;
  otg_power_pkg::link_state_e state_reg;
  logic                       req_write_reg;
  logic [5:0]                 req_addr_reg;
  logic [7:0]                 req_wdata_reg;
  logic                       busy;
  logic                       refused_reg;
  logic                       disch_pend_reg;
  logic                       session_end_flag_reg;
  logic [7:0]                 rdata_reg;
  logic [7:0]                 report_reg;
  logic [14:0]                se0_cnt_reg;
  logic                       se0_ok;
  logic                       charge_ok;
  logic                       report_end_rise;
  logic                       start_auto;
  logic                       start_cmd;
  logic                       sets_bit4;
  logic                       sets_bit3;
  logic [7:0]                 safe_data;

  // ****************************************
  // APB slave
  // ****************************************
  assign apb_acc = psel && penable;
  assign busy    = cmd_pending_reg || (state_reg != otg_power_pkg::LINK_IDLE);
  assign cmd_hit = apb_acc && pwrite && (paddr == `APB_OFF_COMMAND) && !busy;
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !((paddr == `APB_OFF_STATUS && !pwrite)
                              || (paddr == `APB_OFF_COMMAND && !busy));

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == `APB_OFF_STATUS) begin
      prdata[`ST_BIT_BUSY]                    = busy;
      prdata[`ST_BIT_REFUSED]                 = refused_reg;
      prdata[`ST_BIT_DISCH_PEND]              = disch_pend_reg;
      prdata[`ST_BIT_SE0_OK]                  = se0_ok;
      prdata[`ST_BIT_SESSION_END_FLAG]                = session_end_flag_reg;
      prdata[`ST_RDATA_LSB +: 8]              = rdata_reg;
      prdata[`ST_REPORT_LSB +: 8]             = report_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pending_reg <= 1'b0;
      cmd_write_reg   <= 1'b0;
      cmd_addr_reg    <= 6'h00;
      cmd_data_reg    <= 8'h00;
    end else if (cmd_hit) begin
      cmd_pending_reg <= 1'b1;
      cmd_write_reg   <= pwdata[`CMD_BIT_WRITE];
      cmd_addr_reg    <= pwdata[`CMD_ADDR_LSB +: 6];
      cmd_data_reg    <= pwdata[7:0];
    end else if (start_cmd) begin
      cmd_pending_reg <= 1'b0;
    end
  end

  // ****************************************
  // Charge guard
  // ****************************************
  // SE0 must have lasted the full hold time without a break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se0_cnt_reg <= 15'h0000;
    end else if (!line_se0) begin
      se0_cnt_reg <= 15'h0000;
    end else if (!se0_ok) begin
      se0_cnt_reg <= se0_cnt_reg + 15'h0001;
    end
  end

  assign se0_ok    = (32'(se0_cnt_reg) >= SE0_HOLD_CYCLES);
  assign charge_ok = se0_ok && session_end_flag_reg;
  assign sets_bit4 = cmd_write_reg && cmd_data_reg[`OTG_BIT_CHARGE]
                  && (cmd_addr_reg == `OTG_ADDR_WRITE || cmd_addr_reg == `OTG_ADDR_SET);
  assign sets_bit3 = cmd_write_reg && cmd_data_reg[`OTG_BIT_DISCHARGE]
                  && (cmd_addr_reg == `OTG_ADDR_WRITE || cmd_addr_reg == `OTG_ADDR_SET);

  always_comb begin
    safe_data = cmd_data_reg;
    if (cmd_addr_reg != `OTG_ADDR_CLEAR) begin
      safe_data[`OTG_BIT_RESERVED] = 1'b0;
      if (!charge_ok) begin
        safe_data[`OTG_BIT_CHARGE] = 1'b0;
      end
    end
  end

  // ****************************************
  // Transceiver access
  // ****************************************
  assign report_end_rise = phy.rxcmd_valid && phy.rxcmd_data[`RPT_BIT_SESSION_END_FLAG] && !session_end_flag_reg;
  assign start_auto = (state_reg == otg_power_pkg::LINK_IDLE) && disch_pend_reg && session_end_flag_reg;
  assign start_cmd  = (state_reg == otg_power_pkg::LINK_IDLE) && !start_auto && cmd_pending_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= otg_power_pkg::LINK_IDLE;
      req_write_reg <= 1'b0;
      req_addr_reg  <= 6'h00;
      req_wdata_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        otg_power_pkg::LINK_IDLE: begin
          if (start_auto) begin
            state_reg     <= otg_power_pkg::LINK_WAIT;
            req_write_reg <= 1'b1;
            req_addr_reg  <= `OTG_ADDR_CLEAR;
            req_wdata_reg <= 8'h01 << `OTG_BIT_DISCHARGE;
          end else if (start_cmd) begin
            state_reg     <= otg_power_pkg::LINK_WAIT;
            req_write_reg <= cmd_write_reg;
            req_addr_reg  <= cmd_addr_reg;
            req_wdata_reg <= safe_data;
          end
        end
        otg_power_pkg::LINK_WAIT: begin
          if (phy.rsp_valid) begin
            state_reg <= otg_power_pkg::LINK_IDLE;
          end
        end
      endcase
    end
  end

  assign phy.req_valid = (state_reg == otg_power_pkg::LINK_WAIT);
  assign phy.req_write = req_write_reg;
  assign phy.req_addr  = req_addr_reg;
  assign phy.req_wdata = req_wdata_reg;

  // ****************************************
  // Status tracking
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_reg <= 1'b0;
    end else if (start_cmd) begin
      refused_reg <= sets_bit4 && !charge_ok;
    end
  end

  // Waiting for the session end report; the seen session end level wins over a fresh discharge order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disch_pend_reg <= 1'b0;
    end else if (start_auto) begin
      disch_pend_reg <= 1'b0;
    end else if (start_cmd && sets_bit3) begin
      disch_pend_reg <= 1'b1;
    end
  end

  // A discharge order clears the seen level, but a report in the same cycle wins and loads its bit 2; otherwise only a later report with bit 2 set ends it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      session_end_flag_reg <= 1'b0;
    end else if (phy.rxcmd_valid) begin
      session_end_flag_reg <= phy.rxcmd_data[`RPT_BIT_SESSION_END_FLAG];
    end else if (start_cmd && sets_bit3) begin
      session_end_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg  <= 8'h00;
      report_reg <= 8'h00;
    end else begin
      if (phy.rsp_valid && state_reg == otg_power_pkg::LINK_WAIT && !req_write_reg) begin
        rdata_reg <= phy.rsp_rdata;
      end
      if (phy.rxcmd_valid) begin
        report_reg <= phy.rxcmd_data;
      end
    end
  end

  logic unused_rise;
  assign unused_rise = report_end_rise;

endmodule : otg_power_link

// [bench/otg_power_monitor.sv]
// Protocol checker for the link to transceiver register channel
`timescale 1ns/1ps

module otg_power_monitor (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requests
  input  wire logic       req_valid,
  input  wire logic       req_write,
  input  wire logic [5:0] req_addr,
  input  wire logic [7:0] req_wdata,
  // Answers and reports
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_rdata,
  input  wire logic       rxcmd_valid,
  input  wire logic [7:0] rxcmd_data
);
  // ****************************************
  // Shadow of the control register
  // ****************************************
  logic       take;
  logic [7:0] shadow_reg;
  logic       pend_reg;
  assign take = req_valid && !rsp_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_reg <= 8'h06;
    end else if (take && req_write) begin
      case (req_addr)
        6'h0a: shadow_reg <= req_wdata;
        6'h0b: shadow_reg <= shadow_reg | req_wdata;
        6'h0c: shadow_reg <= shadow_reg & ~req_wdata;
        default: ;
      endcase
    end
  end

  // Only a write with bit 3 set to an address other than 0a or 0b ends the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
    end else if (take && req_write && req_wdata[3]) begin
      pend_reg <= (req_addr == 6'h0a) || (req_addr == 6'h0b);
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_answer_next; take |=> rsp_valid; endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("No answer in the cycle after a request");
  property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("Answer lasted more than one cycle");
  property p_no_stray; rsp_valid |-> $past(take); endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("Answer without a request");
  property p_hold; take |=> req_valid && $stable(req_addr) && $stable(req_wdata); endproperty
  a_hold: assert property (p_hold)
    else $error("Request changed before its answer");
  property p_gap; rsp_valid |=> !req_valid; endproperty
  a_gap: assert property (p_gap)
    else $error("No idle cycle after an answer");
  property p_read_value;
    rsp_valid && !$past(req_write) && $past(req_addr) inside {[6'h0a:6'h0c]}
      |-> rsp_rdata == shadow_reg;
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("Read data differs from written history");
  property p_unmapped_zero;
    rsp_valid && !$past(req_write) && !($past(req_addr) inside {[6'h0a:6'h0c]})
      |-> rsp_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("Unmapped read returned nonzero data");
  property p_bit0; take && req_write && req_addr != 6'h0c |-> !req_wdata[0]; endproperty
  a_bit0: assert property (p_bit0)
    else $error("Link wrote one into the reserved bit");
  property p_auto_clear;
    pend_reg && rxcmd_valid && rxcmd_data[2]
      |-> ##[1:8] (take && req_write && req_addr == 6'h0c && req_wdata[3]);
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("Discharge not cleared after session end report");
  property p_rpt_format; rxcmd_valid |-> rxcmd_data[7:3] == 5'h00; endproperty
  a_rpt_format: assert property (p_rpt_format)
    else $error("Report byte has unused bits set");
endmodule : otg_power_monitor

// [bench/otg_bus_power_control_reg_tb.sv]
// Self-checking bench: both ends joined, APB driven, outputs against a register model
`timescale 1ns/1ps

module otg_bus_power_control_reg_tb;
  localparam int SE0_T = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, line_se0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s_q, st;
  logic [2:0]  cmp, rise_en, fall_en;
  logic        fault_in, pin_in, ext_sel, pwr_req, chg_en, dis_en, mpd, ppd;
  logic        vind, sw_out, sw_oe_n;
  logic [7:0]  m_reg;
  logic [7:0]  d;
  bit          m_se;
  int          n_mismatch, n_compared, n_rpt, i, c, e, k;

  otg_power_if otg_power_if_inst ();
  // External pull-up on the open-drain switch pin
  assign pin_in = sw_oe_n ? 1'b1 : sw_out;

  otg_power_device otg_power_device_inst (
    .pclk(pclk), .presetn(presetn), .link(otg_power_if_inst.device),
    .session_end_flag(cmp[2]), .session_valid_cmp(cmp[1]), .vbus_valid_cmp(cmp[0]),
    .fault_in(fault_in), .rise_report_en(rise_en), .fall_report_en(fall_en),
    .external_indicator_select(ext_sel), .bus_power_request(pwr_req),
    .bus_charge_enable(chg_en), .bus_discharge_enable(dis_en),
    .minus_line_pulldown_en(mpd), .plus_line_pulldown_en(ppd), .vbus_valid_indicator(vind),
    .power_switch_out_n_in(pin_in), .power_switch_out_n_out(sw_out),
    .power_switch_out_n_oe_n(sw_oe_n));
  otg_power_link #(.SE0_HOLD_CYCLES(SE0_T)) otg_power_link_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .line_se0(line_se0), .phy(otg_power_if_inst.link));
  otg_power_monitor otg_power_monitor_inst (
    .pclk(pclk), .presetn(presetn), .req_valid(otg_power_if_inst.req_valid),
    .req_write(otg_power_if_inst.req_write), .req_addr(otg_power_if_inst.req_addr),
    .req_wdata(otg_power_if_inst.req_wdata), .rsp_valid(otg_power_if_inst.rsp_valid),
    .rsp_rdata(otg_power_if_inst.rsp_rdata), .rxcmd_valid(otg_power_if_inst.rxcmd_valid),
    .rxcmd_data(otg_power_if_inst.rxcmd_data));

  always #50 pclk = ~pclk;
  // Reports are counted from the value standing just before each edge
  always @(posedge pclk) begin
    if (otg_power_if_inst.rxcmd_valid === 1'b1) n_rpt <= n_rpt + 1;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk); penable <= 1'b1;
    n = 0;
    // Data and refusal are taken at the very edge that sees pready high
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin n_mismatch++; test_done; end
    s_q = pslverr ? 32'hffff_ffff : prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] wd);
    int n;
    apb(1'b1, 12'h000, {15'h0, wr, 2'b00, a, wd});
    n = 0;
    do begin apb(1'b0, 12'h004, 32'h0); st = s_q; n++; end while (st[0] !== 1'b0 && n < 20);
    if (st[0] !== 1'b0) begin n_mismatch++; test_done; end
  endtask : cmd

  task automatic verify;
    chk({ext_sel, ~sw_oe_n, pwr_req, chg_en, dis_en, mpd, ppd}, m_reg[7:1]);
    chk(pin_in, {31'h0, !m_reg[6]});
    for (int j = 0; j < 3; j++) begin
      cmd(1'b0, 6'h0a + 6'(j), 8'h00);
      chk(st[15:8], m_reg);
    end
  endtask : verify

  // Model: reserved bit dropped, charge kept only when the link may grant it
  task automatic acc(input logic [5:0] a, input logic [7:0] wd, input bit ok);
    logic [7:0] w;
    w = wd;
    if (a != 6'h0c) begin w[0] = 1'b0; if (!ok) w[4] = 1'b0; end
    cmd(1'b1, a, wd);
    case (a)
      6'h0a: m_reg = w;
      6'h0b: m_reg = m_reg | w;
      default: m_reg = m_reg & ~w;
    endcase
    chk(st[1], a != 6'h0c && wd[4] && !ok);
    verify;
  endtask : acc

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin #10_000_000; n_mismatch++; test_done; end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    line_se0 = 0; cmp = 0; fault_in = 0; rise_en = 0; fall_en = 0; n_rpt = 0;
    n_mismatch = 0; n_compared = 0; m_reg = 8'h06; m_se = 0;
    void'($urandom(71911));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    verify;
    $display("Test reset values done");
    for (i = 0; i < 9; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      acc(6'h0a + 6'(i % 3), d, 1'b0);
    end
    $display("Test write set clear done");
    cmd(1'b0, 6'h0d, 8'h00);
    chk(st[15:8], 8'h00);
    apb(1'b0, 12'h008, 32'h0);
    chk(s_q, 32'hffff_ffff);
    $display("Test unmapped done");
    for (i = 0; i < 4; i++) begin
      acc(i < 2 ? 6'h0c : 6'h0b, 8'h80, 1'b0);
      fault_in <= i[0]; cmp[0] <= ~i[0];
      repeat (3) @(posedge pclk);
      chk(vind, m_reg[7] ? fault_in : cmp[0]);
    end
    fault_in <= 1'b0; cmp[0] <= 1'b0;
    acc(6'h0c, 8'h80, 1'b0);
    $display("Test indicator select done");
    for (c = 0; c < 3; c++) begin
      for (e = 0; e < 4; e++) begin
        rise_en <= e[0] ? 3'(1 << c) : 3'b000;
        fall_en <= e[1] ? 3'(1 << c) : 3'b000;
        k = n_rpt;
        @(posedge pclk); cmp[c] <= 1'b1;
        repeat (6) @(posedge pclk); cmp[c] <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(n_rpt - k, e[0] + e[1]);
      end
    end
    // A pending discharge is cleared by the link once session end rises
    m_reg[3] = 1'b0;
    verify;
    $display("Test reports done");
    rise_en <= 3'b111; fall_en <= 3'b111;
    acc(6'h0b, 8'h08, 1'b0);
    repeat (10) @(posedge pclk);
    chk(dis_en, 1'b1);
    cmp[2] <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (dis_en !== 1'b0 && k < 20);
    chk(dis_en, 1'b0);
    m_reg[3] = 1'b0; m_se = 1;
    $display("Test discharge done");
    acc(6'h0b, 8'h10, 1'b0);
    line_se0 <= 1'b1;
    repeat (2) @(posedge pclk);
    acc(6'h0b, 8'h10, 1'b0);
    repeat (SE0_T) @(posedge pclk);
    acc(6'h0b, 8'h10, m_se);
    acc(6'h0c, 8'h10, 1'b0);
    $display("Test charge done");
    test_done;
  end
endmodule : otg_bus_power_control_reg_tb
